// file: rtl/lsa_map.svh
// Register offsets, field positions, reset values and timing counts of the live status block.
`ifndef LSA_MAP_SVH
`define LSA_MAP_SVH

// Register offsets on the serial register port.
`define LSA_LIVE_OFS      8'h2F
`define LSA_MASK_OFS      8'h3C
`define LSA_CHLATCH_OFS   8'h50

// Reset values.
`define LSA_LIVE_RST      16'h0000
`define LSA_MASK_RST      15'h0000
`define LSA_CHLATCH_RST   4'h0

// Field positions in the live view.
`define LSA_RSVD_BIT      15
`define LSA_RDY_BIT       14
`define LSA_BUSY_BIT      13
`define LSA_SEL_LSB       10
`define LSA_SEL_MSB       12
`define LSA_SUPPLY_LSB    5
`define LSA_HOT_BIT       4

// Timing: clock period, ready pulse length and channel debounce time.
`define LSA_CLK_NS        100
`define LSA_RDY_NS        24000
`define LSA_RDY_CYC       (`LSA_RDY_NS / `LSA_CLK_NS)
`define LSA_DEB_NS        2000000
`define LSA_DEB_CYC       (`LSA_DEB_NS / `LSA_CLK_NS)

`endif

// file: rtl/lsa_pkg.sv
// Types shared by the live status and alert mask block.
package lsa_pkg;

  // Ready pin sequencer for continuous conversion mode.
  typedef enum logic [0:0] {
    RDY_IDLE  = 1'b0,
    RDY_PULSE = 1'b1
  } lsa_rdy_state_t;

  // One register access from the serial front end.
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } lsa_req_t;

  // Asynchronous fault levels, packed in live view order (bits 9 down to 0).
  typedef struct packed {
    logic       reg1v8;
    logic       digitalSupply;
    logic       analogSupply;
    logic       reg5v;
    logic       chargePump;
    logic       overheat;
    logic [3:0] chan;
  } lsa_async_t;

  // Synchroniser state.
  typedef struct packed {
    lsa_async_t s1;
    lsa_async_t s2;
    lsa_async_t s3;
    lsa_async_t q;
  } lsa_sync_t;

  // Whole state of the main block.
  typedef struct packed {
    logic                 dataRdy;
    logic [14:0]          mask;
    logic [3:0]           chLatch;
    logic [3:0][15:0]     debCnt;
    lsa_rdy_state_t       rdyState;
    logic [7:0]           rdyCnt;
    logic                 adcRdyN;
    logic                 alertN;
    logic [15:0]          rdData;
    logic                 rdValid;
  } lsa_state_t;

endpackage : lsa_pkg

// file: rtl/lsa_sync_filt.sv
// Three-stage synchroniser for the asynchronous fault levels.
`timescale 1ns/100ps

module lsa_sync_filt (
  input  wire logic            clock,
  input  wire logic            rstn,
  input  wire lsa_pkg::lsa_async_t asyncIn,
  output lsa_pkg::lsa_async_t  stableOut
);
  import lsa_pkg::*;

  lsa_sync_t st_q;
  lsa_sync_t st_d;

  // A bit only moves when stages two and three agree, so one late sample cannot glitch it.
  always_comb begin
    st_d    = st_q;
    st_d.s1 = asyncIn;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    st_d.q  = (st_q.s2 & st_q.s3) | (st_q.q & (st_q.s2 | st_q.s3));
  end

  // State register.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign stableOut = st_q.q;

endmodule : lsa_sync_filt

// file: rtl/lsa_live_alert.sv
// Live status view, conversion ready pin, channel fault latches and alert masking.
`timescale 1ns/100ps
`include "lsa_map.svh"

module lsa_live_alert #(
  parameter int DEBOUNCE_CYC = `LSA_DEB_CYC
) (
  input  wire logic                clock,
  input  wire logic                rstn,
  input  wire lsa_pkg::lsa_req_t   req,
  input  wire logic                convDone,
  input  wire logic                contMode,
  input  wire logic                adcBusy,
  input  wire logic [2:0]          convertingInputSel,
  input  wire lsa_pkg::lsa_async_t faultPins,
  input  wire logic [3:0]          chOutFunc,
  input  wire logic [10:0]         alertOther,
  output logic [15:0]              rdData,
  output logic                     rdValid,
  output logic                     adcRdyN,
  output logic                     alertN,
  output logic [3:0]               chFaultLatched
);
  import lsa_pkg::*;

  localparam logic [7:0]  RDY_CYC  = 8'(`LSA_RDY_CYC);
  localparam logic [15:0] DEB_LAST = 16'(DEBOUNCE_CYC - 1);
  localparam logic [15:0] LIVE_RST = `LSA_LIVE_RST;

  lsa_state_t  st_q;
  lsa_state_t  st_d;
  lsa_async_t  liveSync;
  logic [15:0] liveView;
  logic [15:0] latchedAll;
  logic        w1cRdy;
  logic        maskWr;
  logic [3:0]  w1cChan;

  // Fault levels come from analog monitors, so they cross into this clock first.
  lsa_sync_filt u_sync (
    .clock     (clock),
    .rstn      (rstn),
    .asyncIn   (faultPins),
    .stableOut (liveSync)
  );

  // Live view is built fresh every cycle from the sources, never held.
  always_comb begin
    liveView = {1'b0,                 // Reserved bit reads zero.
                st_q.dataRdy,
                adcBusy,
                convertingInputSel,
                liveSync};
  end

  // Latched status word seen by the alert logic, one position per mask bit.
  always_comb begin
    latchedAll = {1'b0, alertOther, st_q.chLatch};
  end

  // Write decodes; clears act only on bits written as one.
  always_comb begin
    w1cRdy  = req.wr && (req.addr == `LSA_LIVE_OFS) && req.wdata[`LSA_RDY_BIT];
    maskWr  = req.wr && (req.addr == `LSA_MASK_OFS);
    w1cChan = (req.wr && (req.addr == `LSA_CHLATCH_OFS)) ? req.wdata[3:0] : 4'h0;
  end

  // Next state of the whole block.
  always_comb begin
    st_d = st_q;

    // A completed conversion wins over a clear in the same cycle, so it is never lost.
    if (convDone) begin
      st_d.dataRdy = 1'b1;
    end else if (w1cRdy) begin
      st_d.dataRdy = 1'b0;
    end

    // Mask bits 14 down to 0 are writable; bit 15 does not exist and reads zero.
    if (maskWr) begin
      st_d.mask = req.wdata[14:0];
    end

    // Channel latches: output functions need the fault held for the debounce time.
    for (int i = 0; i < 4; i++) begin
      if (chOutFunc[i]) begin
        if (!liveSync.chan[i]) begin
          st_d.debCnt[i] = 16'h0000;
        end else if (st_q.debCnt[i] == DEB_LAST) begin
          st_d.chLatch[i] = 1'b1;
        end else begin
          st_d.debCnt[i] = st_q.debCnt[i] + 16'h0001;
        end
      end else begin
        // Input functions debounce upstream, so the live level latches at once.
        st_d.debCnt[i] = 16'h0000;
        if (liveSync.chan[i]) begin
          st_d.chLatch[i] = 1'b1;
        end
      end
      // Clear only when no set is pending this cycle; set wins.
      if (w1cChan[i] && !st_d.chLatch[i]) begin
        st_d.chLatch[i] = 1'b0;
      end else if (w1cChan[i] && !(st_q.chLatch[i] == 1'b0)) begin
        st_d.chLatch[i] = (chOutFunc[i] && liveSync.chan[i] && st_q.debCnt[i] == DEB_LAST)
                          || (!chOutFunc[i] && liveSync.chan[i]);
      end
    end

    // Ready pin sequencer.
    case (st_q.rdyState)
      RDY_IDLE: begin
        if (contMode && convDone) begin
          st_d.rdyState = RDY_PULSE;
          st_d.rdyCnt   = RDY_CYC;
        end
      end
      RDY_PULSE: begin
        if (!contMode) begin
          st_d.rdyState = RDY_IDLE;
          st_d.rdyCnt   = 8'h00;
        end else if (convDone) begin
          st_d.rdyCnt = RDY_CYC;  // A new result restarts the low time.
        end else if (st_q.rdyCnt == 8'h01) begin
          st_d.rdyState = RDY_IDLE;
          st_d.rdyCnt   = 8'h00;
        end else begin
          st_d.rdyCnt = st_q.rdyCnt - 8'h01;
        end
      end
      default: begin
        st_d.rdyState = RDY_IDLE;
        st_d.rdyCnt   = 8'h00;
      end
    endcase

    // The pin is active low: single mode mirrors the flag, continuous mode a timed pulse.
    if (contMode) begin
      st_d.adcRdyN = !(st_d.rdyState == RDY_PULSE);
    end else begin
      st_d.adcRdyN = !st_d.dataRdy;
    end

    // Masked bits stay recorded but cannot pull the pin.
    st_d.alertN = !(|(latchedAll & ~{1'b0, st_q.mask}));

    // Register reads answer one cycle later; unmapped offsets read zero.
    st_d.rdValid = req.rd;
    if (req.rd) begin
      case (req.addr)
        `LSA_LIVE_OFS:    st_d.rdData = liveView;
        `LSA_MASK_OFS:    st_d.rdData = {1'b0, st_q.mask};
        `LSA_CHLATCH_OFS: st_d.rdData = {12'h000, st_q.chLatch};
        default:          st_d.rdData = 16'h0000;
      endcase
    end
  end

  // State register; everything returns to zero except the active-low adcRdyN and alertN, which reset high, leaving all alerts unmasked.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_q         <= '0;
      st_q.dataRdy <= LIVE_RST[`LSA_RDY_BIT];
      st_q.mask    <= `LSA_MASK_RST;
      st_q.chLatch <= `LSA_CHLATCH_RST;
      st_q.adcRdyN <= 1'b1;
      st_q.alertN  <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs come straight from the state register.
  assign rdData         = st_q.rdData;
  assign rdValid        = st_q.rdValid;
  assign adcRdyN        = st_q.adcRdyN;
  assign alertN         = st_q.alertN;
  assign chFaultLatched = st_q.chLatch;

  // Checks on the live view: a read returns the level of the cycle it was taken.
  property p_live_now;
    @(posedge clock) disable iff (!rstn)
    (req.rd && req.addr == `LSA_LIVE_OFS)
      |=> (rdData[9:0] == $past(liveSync)) && (rdData[15] == 1'b0);
  endproperty
  a_live_now: assert property (p_live_now) else $error("Live view read stale");

  property p_live_sel;
    @(posedge clock) disable iff (!rstn)
    (req.rd && req.addr == `LSA_LIVE_OFS)
      |=> rdData[12:10] == $past(convertingInputSel) && rdData[13] == $past(adcBusy);
  endproperty
  a_live_sel: assert property (p_live_sel) else $error("Busy or input select wrong");

  property p_live_hot_chan;
    @(posedge clock) disable iff (!rstn)
    (req.rd && req.addr == `LSA_LIVE_OFS)
      |=> rdData[4] == $past(liveSync.overheat) && rdData[3:0] == $past(liveSync.chan);
  endproperty
  a_live_hot_chan: assert property (p_live_hot_chan) else $error("Hot or chan bit wrong");

  // Data ready flag: set on completion, cleared only by a one in bit 14.
  property p_rdy_set;
    @(posedge clock) disable iff (!rstn)
    convDone |=> st_q.dataRdy;
  endproperty
  a_rdy_set: assert property (p_rdy_set) else $error("Ready flag missed a conversion");

  property p_rdy_hold;
    @(posedge clock) disable iff (!rstn)
    (st_q.dataRdy && !w1cRdy) |=> st_q.dataRdy;
  endproperty
  a_rdy_hold: assert property (p_rdy_hold) else $error("Ready flag dropped unasked");

  // Single mode pin mirrors the flag.
  property p_pin_single;
    @(posedge clock) disable iff (!rstn)
    (!contMode && $past(!contMode)) |-> adcRdyN == !st_q.dataRdy;
  endproperty
  a_pin_single: assert property (p_pin_single) else $error("Ready pin not following flag");

  // Continuous mode pin: still low eight cycles into the pulse, high after the last count.
  property p_pin_cont;
    @(posedge clock) disable iff (!rstn)
    (contMode && convDone ##1 (contMode && !convDone)[*8])
      |-> !adcRdyN && st_q.rdyCnt == RDY_CYC - 8'd7;
  endproperty
  a_pin_cont: assert property (p_pin_cont) else $error("Ready pulse count wrong");

  property p_pin_end;
    @(posedge clock) disable iff (!rstn)
    (st_q.rdyState == RDY_PULSE && st_q.rdyCnt == 8'h01 && contMode && !convDone)
      |=> adcRdyN;
  endproperty
  a_pin_end: assert property (p_pin_end) else $error("Ready pin stayed low");

  // Alert pin against latched status and mask.
  property p_alert;
    @(posedge clock) disable iff (!rstn)
    1'b1 |=> alertN == !(|($past(latchedAll) & ~{1'b0, $past(st_q.mask)}));
  endproperty
  a_alert: assert property (p_alert) else $error("Alert pin disagrees with mask");

  property p_mask_store;
    @(posedge clock) disable iff (!rstn)
    maskWr |=> st_q.mask == $past(req.wdata[14:0]);
  endproperty
  a_mask_store: assert property (p_mask_store) else $error("Mask write lost");

  // Debounced latch sets only after the full interval of a held fault.
  property p_deb;
    @(posedge clock) disable iff (!rstn)
    ($rose(st_q.chLatch[0]) && $past(chOutFunc[0])) |-> $past(st_q.debCnt[0]) == DEB_LAST;
  endproperty
  a_deb: assert property (p_deb) else $error("Channel latch set early");

  // Write-one clear empties idle input-function latches; masking never clears a latch.
  property p_chan_clear;
    @(posedge clock) disable iff (!rstn)
    (w1cChan == 4'hF && !(|liveSync.chan) && !(|chOutFunc)) |=> st_q.chLatch == 4'h0;
  endproperty
  a_chan_clear: assert property (p_chan_clear) else $error("Channel latch kept");

  property p_mask_keeps;
    @(posedge clock) disable iff (!rstn)
    (st_q.chLatch[0] && st_q.mask[0] && !w1cChan[0]) |=> st_q.chLatch[0];
  endproperty
  a_mask_keeps: assert property (p_mask_keeps) else $error("Masked status lost");

  // Once the timed pulse is over, a still-set flag must not hold the pin low.
  property p_cont_high;
    @(posedge clock) disable iff (!rstn)
    (contMode && st_q.dataRdy && st_q.rdyState == RDY_IDLE && !convDone) |=> adcRdyN;
  endproperty
  a_cont_high: assert property (p_cont_high) else $error("Ready pin held by flag");

  property p_reset_zero;
    @(posedge clock)
    $rose(rstn) |-> st_q.mask == 15'h0000 && !st_q.dataRdy;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("Reset value not zero");

  // Main scenarios.
  c_cont_pulse: cover property (@(posedge clock) disable iff (!rstn)
    contMode && convDone ##1 !adcRdyN);
  c_alert_on: cover property (@(posedge clock) disable iff (!rstn) $fell(alertN));
  c_masked: cover property (@(posedge clock) disable iff (!rstn)
    (|latchedAll) && alertN);
  c_chan_latch: cover property (@(posedge clock) disable iff (!rstn)
    $rose(st_q.chLatch[0]));

endmodule : lsa_live_alert

// file: verif/lsa_host_model.sv
// Host processor model that drives the register port of the live status block.
`timescale 1ns/100ps

module lsa_host_model (
  input  wire logic         clock,
  output lsa_pkg::lsa_req_t req,
  input  wire logic [15:0]  rdData,
  input  wire logic         rdValid
);
  import lsa_pkg::*;

  // The port starts idle with both strobes low.
  initial begin
    req = '0;
  end

  // One access per call: raised after a falling edge and held over exactly one rising edge.
  // Once it is released, address and data are inverted so that a stale value never looks valid.
  // A read that comes back without its valid pulse returns unknowns, so it cannot match.
  task automatic access(input logic w, input logic [7:0] a, input logic [15:0] d,
                        output logic [15:0] q);
    @(negedge clock);
    req = '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge clock);
    req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    q = (rdValid === 1'b1) ? rdData : 16'hxxxx;
  endtask : access
endmodule : lsa_host_model

// file: verif/test_live_status_alert_mask.sv
// Self-checking testbench of the live status and alert mask block.
`timescale 1ns/100ps

module test_live_status_alert_mask;
  import lsa_pkg::*;

  logic        clock = 1'b0;
  logic        rstn, convDone, contMode, adcBusy;
  logic [2:0]  convertingInputSel;
  lsa_async_t  faultPins;
  logic [3:0]  chOutFunc, chFaultLatched, latchM;
  logic [10:0] alertOther;
  logic [15:0] rdData, q, rnd;
  logic [14:0] maskM;
  logic        rdValid, adcRdyN, alertN;
  lsa_req_t    req;
  int          fails = 0, checks = 0, cycles = 0, n;
  integer      seed = 32'h514f4d23;

  lsa_host_model host (.clock(clock), .req(req), .rdData(rdData), .rdValid(rdValid));

  lsa_live_alert #(.DEBOUNCE_CYC(8)) DUT (
    .clock(clock), .rstn(rstn), .req(req), .convDone(convDone), .contMode(contMode),
    .adcBusy(adcBusy), .convertingInputSel(convertingInputSel), .faultPins(faultPins),
    .chOutFunc(chOutFunc), .alertOther(alertOther), .rdData(rdData), .rdValid(rdValid),
    .adcRdyN(adcRdyN), .alertN(alertN), .chFaultLatched(chFaultLatched)
  );

  // A 10 MHz clock.
  always #50 clock = ~clock;

  // Cycle ceiling: the whole sequence needs well under 3000 cycles.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      complete_run();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run

  // Pulses the conversion-done strobe for one cycle.
  task automatic conv_pulse;
    @(negedge clock);
    convDone = 1'b1;
    @(negedge clock);
    convDone = 1'b0;
  endtask : conv_pulse

  // Expected alert pin level from the model's latched bits and mask.
  function automatic logic [15:0] alert_exp;
    return 16'(!(|({alertOther, latchM} & ~maskM)));
  endfunction : alert_exp

  // Main sequence; every input changes only after a falling edge.
  initial begin
    rstn = 1'b0;
    {convDone, contMode, adcBusy, convertingInputSel, chOutFunc, alertOther} = '0;
    faultPins = '0;
    latchM = 4'h0;
    maskM = 15'h0000;
    repeat (4) @(negedge clock);
    rstn = 1'b1;
    host.access(1'b0, 8'h2F, 16'h0000, q); check(q, 16'h0000);
    host.access(1'b0, 8'h3C, 16'h0000, q); check(q, 16'h0000);
    check(16'(alertN), 16'h0001);
    host.access(1'b0, 8'h77, 16'h0000, q); check(q, 16'h0000);
    // Live view: every input code with random busy and fault levels, then a write of all ones except ready bit 14.
    for (int i = 0; i < 8; i++) begin
      rnd = 16'($random(seed));
      adcBusy = rnd[10];
      convertingInputSel = 3'(i);
      faultPins = rnd[9:0];
      latchM |= rnd[3:0];
      repeat (6) @(negedge clock);
      host.access(1'b0, 8'h2F, 16'h0000, q); check(q, {2'b00, rnd[10], 3'(i), rnd[9:0]});
      host.access(1'b1, 8'h2F, 16'hBFFF, q);
      host.access(1'b0, 8'h2F, 16'h0000, q); check(q, {2'b00, rnd[10], 3'(i), rnd[9:0]});
      check(16'(chFaultLatched), 16'(latchM));
    end
    faultPins = '0;
    adcBusy = 1'b0;
    convertingInputSel = 3'b000;
    repeat (6) @(negedge clock);
    host.access(1'b1, 8'h50, 16'h000F, q);
    latchM = 4'h0;
    check(16'(chFaultLatched), 16'h0000);
    // Single mode: the pin follows the flag until a write-one clear.
    conv_pulse();
    check(16'(adcRdyN), 16'h0000);
    repeat (30) @(negedge clock);
    host.access(1'b0, 8'h2F, 16'h0000, q); check(q, 16'h4000);
    check(16'(adcRdyN), 16'h0000);
    host.access(1'b1, 8'h2F, 16'h4000, q); check(16'(adcRdyN), 16'h0001);
    host.access(1'b0, 8'h2F, 16'h0000, q); check(q, 16'h0000);
    // Continuous mode: the pin is low for 24 us, the flag stays set.
    contMode = 1'b1;
    conv_pulse();
    n = 0;
    while (adcRdyN === 1'b0 && n < 1000) begin
      n++;
      @(negedge clock);
    end
    check(16'(n), 16'd240);
    // A new result in mid-pulse restarts the full low time.
    conv_pulse();
    repeat (100) @(negedge clock);
    conv_pulse();
    n = 0;
    while (adcRdyN === 1'b0 && n < 1000) begin
      n++;
      @(negedge clock);
    end
    check(16'(n), 16'd240);
    host.access(1'b0, 8'h2F, 16'h0000, q); check(q, 16'h4000);
    host.access(1'b1, 8'h2F, 16'h4000, q);
    contMode = 1'b0;
    // Mask and alert: random masks, latched sources and channel faults; first pass masks all.
    for (int i = 0; i < 12; i++) begin
      rnd = (i == 0) ? 16'hFFFF : 16'($random(seed));
      host.access(1'b1, 8'h3C, rnd, q);
      maskM = rnd[14:0];
      host.access(1'b0, 8'h3C, 16'h0000, q); check(q, {1'b0, maskM});
      rnd = 16'($random(seed));
      alertOther = (i == 0) ? 11'h7FF : rnd[14:4];
      faultPins = {6'b00_0000, rnd[3:0]};
      latchM |= rnd[3:0];
      repeat (6) @(negedge clock);
      check(16'(chFaultLatched), 16'(latchM));
      check(16'(alertN), alert_exp());
    end
    faultPins = '0;
    host.access(1'b1, 8'h3C, 16'h0000, q);
    maskM = 15'h0000;
    // Output function: a short fault is filtered, a long one latches.
    repeat (6) @(negedge clock);
    host.access(1'b1, 8'h50, 16'h000F, q);
    latchM = 4'h0;
    chOutFunc = 4'hF;
    faultPins.chan = 4'h1;
    repeat (5) @(negedge clock);
    faultPins.chan = 4'h0;
    repeat (8) @(negedge clock);
    check(16'(chFaultLatched), 16'h0000);
    faultPins.chan = 4'h1;
    repeat (20) @(negedge clock);
    latchM = 4'h1;
    check(16'(chFaultLatched), 16'h0001);
    check(16'(alertN), alert_exp());
    // A second reset in mid-run, with a mask, a flag and a latch set, must clear them all.
    host.access(1'b1, 8'h3C, 16'h7FFF, q);
    conv_pulse();
    faultPins = '0;
    rstn = 1'b0;
    @(negedge clock);
    check(16'(alertN), 16'h0001);
    check(16'(adcRdyN), 16'h0001);
    check(16'(chFaultLatched), 16'h0000);
    rstn = 1'b1;
    latchM = 4'h0;
    maskM = 15'h0000;
    host.access(1'b0, 8'h3C, 16'h0000, q); check(q, 16'h0000);
    host.access(1'b0, 8'h2F, 16'h0000, q); check(q, 16'h0000);
    complete_run();
  end
endmodule : test_live_status_alert_mask
